// >>> design/output_compare_channel.sv
// Output compare channel with one-shot, toggle, pulse and PWM modes
`include "output_compare_params.svh"

module output_compare_channel (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire output_compare_pkg::bus_req_s  bus_req,
    output logic [`OCC_DATA_W-1:0]             bus_rdata,
    input  wire output_compare_pkg::time_base_s time_base,
    input  wire logic                          cpu_idle,
    input  wire logic                          compare_fault_input,
    input  wire logic                          port_latch_level,
    output logic                               compare_output_pin,
    output logic                               compare_event
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic                        halt_when_idle;   // Stop in idle
        logic                        time_base_select; // Timer choice
        logic [2:0]                  channel_mode_field;
        logic [15:0]                 primary_compare_value;
        logic [15:0]                 secondary_compare_value;
        logic                        level;            // Channel level
        logic                        pwm_fault_status; // Fault flag
        logic                        fault_prev;       // Last fault in
        output_compare_pkg::phase_e  phase;            // Pulse phase
        logic                        pin;              // Pin register
        logic                        event_pulse;      // Edge event
        logic [`OCC_DATA_W-1:0]      rdata;            // Read data
    } state_s;

    state_s q;                        // Registered state
    state_s d;                        // Next state

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Level that a mode takes on entry
    function automatic logic entry_level(
        input logic [2:0]  mode,
        input logic        cur,
        input logic [15:0] duty
    );
        logic lvl;
        lvl = 1'b0;
        unique case (mode)
            `OCC_MODE_LSHOT:  lvl = 1'b1;
            `OCC_MODE_TOGGLE: lvl = cur;
            `OCC_MODE_PWM,
            `OCC_MODE_PWMF:   lvl = (duty != `OCC_ZERO16);
            default:          lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Whether an output edge raises the channel event
    function automatic logic edge_event(
        input logic [2:0] mode,
        input logic       old_lvl,
        input logic       new_lvl
    );
        logic rise;
        logic fall;
        logic ev;
        rise = ~old_lvl & new_lvl;
        fall = old_lvl & ~new_lvl;
        ev   = 1'b0;
        unique case (mode)
            `OCC_MODE_HSHOT:  ev = rise;
            `OCC_MODE_LSHOT:  ev = fall;
            `OCC_MODE_TOGGLE: ev = rise | fall;
            `OCC_MODE_DSHOT,
            `OCC_MODE_PULSE:  ev = fall;
            default:          ev = 1'b0;
        endcase
        return ev;
    endfunction

    // Control register image with unused bits as zero
    function automatic logic [`OCC_DATA_W-1:0] ctrl_image(
        input state_s s
    );
        logic [`OCC_DATA_W-1:0] img;
        img = `OCC_ZERO16;
        img[`OCC_BIT_HALT]  = s.halt_when_idle;
        img[`OCC_BIT_FAULT] = s.pwm_fault_status;
        img[`OCC_BIT_TSEL]  = s.time_base_select;
        img[`OCC_MODE_HI:`OCC_MODE_LO] = s.channel_mode_field;
        return img;
    endfunction

    // ------------------------------------------------------------
    // Decoded conditions
    // ------------------------------------------------------------
    logic [15:0] timer;               // Selected time base count
    logic        halted;              // Channel frozen by idle
    logic        ctrl_wr;             // Control register write
    logic        match_pri;           // Timer equals primary
    logic        match_sec;           // Timer equals secondary
    logic        period_start;        // Timer at zero
    logic        fault_on;            // Fault input asserted (low)
    logic        fault_fall;          // Fault input falling edge

    // Time base choice and compare decode
    always_comb begin
        timer = q.time_base_select ? time_base.second_time_base
                                   : time_base.first_time_base;
        halted       = q.halt_when_idle & cpu_idle;
        ctrl_wr      = bus_req.wr & (bus_req.addr == `OCC_OFF_CTRL);
        match_pri    = (timer == q.primary_compare_value);
        match_sec    = (timer == q.secondary_compare_value);
        period_start = (timer == `OCC_ZERO16);
        fault_on     = ~compare_fault_input;
        fault_fall   = q.fault_prev & ~compare_fault_input;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d             = q;
        d.event_pulse = 1'b0;
        d.rdata       = `OCC_ZERO16;
        d.fault_prev  = compare_fault_input;

        // Register writes; unused control bits are dropped
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `OCC_OFF_CTRL: begin
                    d.halt_when_idle   = bus_req.wdata[`OCC_BIT_HALT];
                    d.time_base_select = bus_req.wdata[`OCC_BIT_TSEL];
                    d.channel_mode_field =
                        bus_req.wdata[`OCC_MODE_HI:`OCC_MODE_LO];
                end
                `OCC_OFF_PRI: begin
                    d.primary_compare_value = bus_req.wdata;
                end
                `OCC_OFF_SEC: begin
                    d.secondary_compare_value = bus_req.wdata;
                end
                default: begin
                    // Unmapped address: write ignored
                end
            endcase
        end

        if (ctrl_wr &&
            (d.channel_mode_field != q.channel_mode_field)) begin
            d.level = entry_level(d.channel_mode_field, q.level,
                                  q.primary_compare_value);
            d.phase = output_compare_pkg::PH_WAIT;
        end else if (!ctrl_wr && !halted) begin
            unique case (q.channel_mode_field)
                `OCC_MODE_HSHOT: begin
                    if (match_pri) begin
                        d.level = 1'b1;
                    end
                end
                `OCC_MODE_LSHOT: begin
                    if (match_pri) begin
                        d.level = 1'b0;
                    end
                end
                `OCC_MODE_TOGGLE: begin
                    if (match_pri) begin
                        d.level = ~q.level;
                    end
                end
                `OCC_MODE_DSHOT,
                `OCC_MODE_PULSE: begin
                    unique case (q.phase)
                        output_compare_pkg::PH_WAIT: begin
                            if (match_pri) begin
                                d.level = 1'b1;
                                d.phase = output_compare_pkg::PH_HIGH;
                            end
                        end
                        output_compare_pkg::PH_HIGH: begin
                            if (match_sec) begin
                                d.level = 1'b0;
                                d.phase = (q.channel_mode_field ==
                                           `OCC_MODE_DSHOT)
                                        ? output_compare_pkg::PH_DONE
                                        : output_compare_pkg::PH_WAIT;
                            end
                        end
                        output_compare_pkg::PH_DONE: begin
                            // Shot finished, hold low
                        end
                    endcase
                end
                `OCC_MODE_PWM: begin
                    if (period_start) begin
                        d.primary_compare_value =
                            q.secondary_compare_value;
                        d.level = (q.secondary_compare_value !=
                                   `OCC_ZERO16);
                    end else if (match_pri) begin
                        d.level = 1'b0;
                    end
                end
                `OCC_MODE_PWMF: begin
                    if (fault_on) begin
                        d.pwm_fault_status = 1'b1;
                        d.level            = 1'b0;
                    end else if (period_start) begin
                        // Fault gone: resume and clear flag
                        d.pwm_fault_status = 1'b0;
                        d.primary_compare_value =
                            q.secondary_compare_value;
                        d.level = (q.secondary_compare_value !=
                                   `OCC_ZERO16);
                    end else if (match_pri && !q.pwm_fault_status) begin
                        d.level = 1'b0;
                    end
                    if (fault_fall) begin
                        d.event_pulse = 1'b1;
                    end
                end
                default: begin
                    // Disabled: nothing runs
                end
            endcase
            if (edge_event(q.channel_mode_field, q.level, d.level)) begin
                d.event_pulse = 1'b1;
            end
        end

        d.pin = (d.channel_mode_field == `OCC_MODE_OFF)
              ? port_latch_level : d.level;

        // Register reads, answered in the next cycle
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `OCC_OFF_CTRL: d.rdata = ctrl_image(q);
                `OCC_OFF_PRI:  d.rdata = q.primary_compare_value;
                `OCC_OFF_SEC:  d.rdata = q.secondary_compare_value;
                default:       d.rdata = `OCC_ZERO16;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            q.halt_when_idle          <= 1'b0;
            q.time_base_select        <= 1'b0;
            q.channel_mode_field      <= `OCC_ZERO3;
            q.primary_compare_value   <= `OCC_ZERO16;
            q.secondary_compare_value <= `OCC_ZERO16;
            q.level                   <= 1'b0;
            q.pwm_fault_status        <= 1'b0;
            q.fault_prev              <= 1'b1;
            q.phase                   <= output_compare_pkg::PH_WAIT;
            q.pin                     <= 1'b0;
            q.event_pulse             <= 1'b0;
            q.rdata                   <= `OCC_ZERO16;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign bus_rdata          = q.rdata;
    assign compare_output_pin = q.pin;
    assign compare_event      = q.event_pulse;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic running;                    // Mode logic active this cycle
    assign running = !ctrl_wr && !halted;
    sequence s_match_run(logic [2:0] m);
        running && (q.channel_mode_field == m) && match_pri;
    endsequence
    sequence s_fault_drop;
        running && (q.channel_mode_field == `OCC_MODE_PWMF) &&
        fault_fall;
    endsequence
    a_disabled_pin: assert property (
        @(posedge clock) disable iff (rst)
        (q.channel_mode_field == `OCC_MODE_OFF) && !ctrl_wr
        |=> compare_output_pin == $past(port_latch_level))
        else $error("pin not from port latch when disabled");
    a_high_shot: assert property (
        @(posedge clock) disable iff (rst)
        s_match_run(`OCC_MODE_HSHOT) ##0 !q.level
        |=> q.level && compare_event)
        else $error("active-high shot missed its rise");
    a_low_shot: assert property (
        @(posedge clock) disable iff (rst)
        s_match_run(`OCC_MODE_LSHOT) ##0 q.level
        |=> !q.level && compare_event)
        else $error("active-low shot missed its fall");
    a_toggle_flip: assert property (
        @(posedge clock) disable iff (rst)
        s_match_run(`OCC_MODE_TOGGLE)
        |=> (q.level != $past(q.level)) && compare_event)
        else $error("toggle did not invert on match");
    a_pwm_silent: assert property (
        @(posedge clock) disable iff (rst)
        (q.channel_mode_field == `OCC_MODE_PWM)
        |=> !compare_event)
        else $error("plain PWM raised an event");
    a_pwm_entry: assert property (
        @(posedge clock) disable iff (rst)
        ctrl_wr && (bus_req.wdata[`OCC_MODE_HI:`OCC_MODE_LO] ==
                    `OCC_MODE_PWM) &&
        (q.channel_mode_field != `OCC_MODE_PWM)
        |=> q.level == ($past(q.primary_compare_value) != `OCC_ZERO16))
        else $error("PWM entry level wrong");
    a_fault_event: assert property (
        @(posedge clock) disable iff (rst)
        s_fault_drop |=> compare_event && q.pwm_fault_status
                         && !q.level)
        else $error("fault drop not reported");
    a_idle_freeze: assert property (
        @(posedge clock) disable iff (rst)
        halted && !bus_req.wr |=> $stable(q.level) && !compare_event)
        else $error("channel moved while halted in idle");
    a_fault_sticky: assert property (
        @(posedge clock) disable iff (rst)
        q.pwm_fault_status && !compare_fault_input ##1 !ctrl_wr
        |-> q.pwm_fault_status)
        else $error("fault flag cleared while fault present");
    a_ctrl_read: assert property (
        @(posedge clock) disable iff (rst)
        bus_req.rd && (bus_req.addr == `OCC_OFF_CTRL)
        |=> (bus_rdata[15:14] == 2'h0) && (bus_rdata[12:5] == 8'h00)
            && (bus_rdata[2:0] == $past(q.channel_mode_field)))
        else $error("control read image wrong");
endmodule

// >>> design/output_compare_params.svh
// Constants for the output compare channel: offsets, fields, codes
`ifndef OUTPUT_COMPARE_PARAMS_SVH
`define OUTPUT_COMPARE_PARAMS_SVH

// ----------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------
`define OCC_ADDR_W       4
`define OCC_DATA_W       16
`define OCC_OFF_CTRL     4'h0
`define OCC_OFF_PRI      4'h4
`define OCC_OFF_SEC      4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define OCC_BIT_HALT     13
`define OCC_BIT_FAULT    4
`define OCC_BIT_TSEL     3
`define OCC_MODE_HI      2
`define OCC_MODE_LO      0

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define OCC_MODE_OFF     3'h0
`define OCC_MODE_HSHOT   3'h1
`define OCC_MODE_LSHOT   3'h2
`define OCC_MODE_TOGGLE  3'h3
`define OCC_MODE_DSHOT   3'h4
`define OCC_MODE_PULSE   3'h5
`define OCC_MODE_PWM     3'h6
`define OCC_MODE_PWMF    3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCC_ZERO16       16'h0000
`define OCC_ZERO3        3'h0

`endif

// >>> design/output_compare_pkg.sv
// Types shared by the output compare channel and its users
`include "output_compare_params.svh"

package output_compare_pkg;

    // ------------------------------------------------------------
    // Register bus request from software
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`OCC_ADDR_W-1:0] addr;   // Byte address
        logic [`OCC_DATA_W-1:0] wdata;  // Write data
        logic                   wr;     // Write strobe
        logic                   rd;     // Read strobe
    } bus_req_s;

    // ------------------------------------------------------------
    // Time base inputs
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] first_time_base;   // First timer count
        logic [15:0] second_time_base;  // Second timer count
    } time_base_s;

    // ------------------------------------------------------------
    // Pulse sequencing phase, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_WAIT = 3'h1,                 // Waiting for first match
        PH_HIGH = 3'h2,                 // Pulse is high
        PH_DONE = 3'h4                  // Single shot finished
    } phase_e;

endpackage

// >>> bench/output_compare_channel_tb_top.sv
// Self-checking bench for the output compare channel
`include "output_compare_params.svh"

module output_compare_channel_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    logic                               clock;       // Bench clock
    logic                               rst;         // Sync reset
    output_compare_pkg::bus_req_s       req;         // Register request
    logic [`OCC_DATA_W-1:0]             rdata;       // Register read data
    output_compare_pkg::time_base_s     tb_in;       // Both timer counts
    logic                               cpu_idle;    // Processor idle
    logic                               fault_n;     // Fault, active low
    logic                               latch_lvl;   // Port latch level
    logic                               pin;         // Channel output
    logic                               evt;         // Event pulse
    logic                               use_second;  // Timer the bench drives
    logic                               seen;        // Event caught
    integer                             seed;        // Random seed
    integer                             n_errors;    // Mismatch count
    integer                             checks_done; // Compare count

    output_compare_channel dut (
        .clock               (clock),
        .rst                 (rst),
        .bus_req             (req),
        .bus_rdata           (rdata),
        .time_base           (tb_in),
        .cpu_idle            (cpu_idle),
        .compare_fault_input (fault_n),
        .port_latch_level    (latch_lvl),
        .compare_output_pin  (pin),
        .compare_event       (evt)
    );

    // ------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------
    // Free running 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Idle timer value: top bit set so it never matches a compare value
    function automatic logic [15:0] idle_val();
        logic [31:0] r;
        r = $random(seed);
        return {1'b1, r[14:0]};
    endfunction

    // Compare a seen value with the expected one
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One-cycle register write
    task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
    endtask

    // One-cycle register read; data stands one cycle only
    task automatic bus_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        #1;
        check(rdata, exp, "read data");
        @(posedge clock);
        #1;
        check(rdata, 16'h0000, "read data after");
    endtask

    // Present one timer value for a cycle, then check pin and event
    task automatic tick(input logic [15:0] v, input logic ep,
                        input logic ee);
        @(posedge clock);
        if (use_second)
            tb_in.second_time_base <= v;
        else
            tb_in.first_time_base <= v;
        @(posedge clock);
        tb_in <= {idle_val(), idle_val()};
        #1;
        check({15'h0, pin}, {15'h0, ep}, "pin");
        check({15'h0, evt}, {15'h0, ee}, "event");
    endtask

    // Let a mode write settle, then check the entry level
    task automatic entry(input logic [15:0] ctl, input logic ep);
        bus_write(`OCC_OFF_CTRL, ctl);
        repeat (2) @(posedge clock);
        #1;
        check({15'h0, pin}, {15'h0, ep}, "entry level");
    endtask

    // ------------------------------------------------------------
    // Watchdog against a hung run
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h42ca;
        n_errors = 0;
        checks_done = 0;
        rst = 1'b1;
        req = '0;
        tb_in = {idle_val(), idle_val()};
        cpu_idle = 1'b0;
        fault_n = 1'b1;
        latch_lvl = 1'b0;
        use_second = 1'b0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        bus_read(`OCC_OFF_CTRL, 16'h0000);
        // Disabled channel: pin follows random port latch levels
        repeat (4) begin
            @(posedge clock);
            latch_lvl <= 1'($random(seed));
            repeat (2) @(posedge clock);
            #1;
            check({15'h0, pin}, {15'h0, latch_lvl}, "latch");
        end
        bus_write(`OCC_OFF_PRI, 16'h0005);
        bus_write(`OCC_OFF_SEC, 16'h0009);
        // Reserved and flag bits written as ones are dropped
        entry(16'hfff9, 1'b0);
        bus_read(`OCC_OFF_CTRL, 16'h2009);
        tick(16'h0005, 1'b0, 1'b0);
        use_second = 1'b1;
        @(posedge clock);
        cpu_idle <= 1'b1;
        tick(16'h0005, 1'b0, 1'b0);
        @(posedge clock);
        cpu_idle <= 1'b0;
        tick(16'h0005, 1'b1, 1'b1);
        use_second = 1'b0;
        entry(16'h0002, 1'b1);
        tick(16'h0005, 1'b0, 1'b1);
        entry(16'h0003, 1'b0);
        tick(16'h0005, 1'b1, 1'b1);
        tick(16'h0005, 1'b0, 1'b1);
        entry(16'h0004, 1'b0);
        tick(16'h0005, 1'b1, 1'b0);
        tick(16'h0009, 1'b0, 1'b1);
        tick(16'h0005, 1'b0, 1'b0);
        entry(16'h0005, 1'b0);
        tick(16'h0005, 1'b1, 1'b0);
        tick(16'h0009, 1'b0, 1'b1);
        tick(16'h0005, 1'b1, 1'b0);
        entry(16'h0006, 1'b1);
        tick(16'h0000, 1'b1, 1'b0);
        tick(16'h0009, 1'b0, 1'b0);
        bus_write(`OCC_OFF_SEC, 16'h0000);
        tick(16'h0000, 1'b0, 1'b0);
        bus_write(`OCC_OFF_SEC, 16'h0009);
        entry(16'h0007, 1'b0);
        tick(16'h0000, 1'b1, 1'b0);
        // Fault falls: event within a few cycles, pin forced low
        @(posedge clock);
        fault_n <= 1'b0;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clock);
            #1;
            seen = seen | (evt === 1'b1);
        end
        check({15'h0, seen}, 16'h0001, "fault event");
        check({15'h0, pin}, 16'h0000, "fault pin");
        bus_read(`OCC_OFF_CTRL, 16'h0017);
        bus_write(`OCC_OFF_CTRL, 16'h0007);
        bus_read(`OCC_OFF_CTRL, 16'h0017);
        @(posedge clock);
        fault_n <= 1'b1;
        tick(16'h0000, 1'b1, 1'b0);
        bus_read(`OCC_OFF_CTRL, 16'h0007);
        bus_read(4'hc, 16'h0000);
        entry(16'h0000, latch_lvl);
        test_done();
    end

endmodule
